// ---- blerc_cfg.svh ----
`ifndef BLERC_CFG_SVH
`define BLERC_CFG_SVH
`define BLERC_CLK_MHZ 20
`define BLERC_CNT_W 32
`define BLERC_CRC_W 16
`define BLERC_CRC_POLY 16'h1021
`define BLERC_CRC_INIT 16'hffff
`define BLERC_FIFO_W 2
`define BLERC_FIFO_D 8
`define BLERC_CLK_LOSS_US 20
`define BLERC_CLK_LOSS_CYC ((`BLERC_CLK_LOSS_US * `BLERC_CLK_MHZ) > 0 ? (`BLERC_CLK_LOSS_US * `BLERC_CLK_MHZ) : 1)
`define BLERC_DATA_IDLE_BITS 64
`define BLERC_RATE_SHIFT 20
`endif

// ---- blerc_pkg.sv ----
package blerc_pkg;
    typedef enum logic [3:0] {
        BLERC_CAUSE_NONE = 4'h0,
        BLERC_CAUSE_USER = 4'h1,
        BLERC_CAUSE_BLOCKS = 4'h2,
        BLERC_CAUSE_ERRORS = 4'h4,
        BLERC_CAUSE_TIMEOUT = 4'h8
    } blerc_cause_t;

    typedef struct packed {
        logic data;
        logic user;
    } blerc_bit_t;

    typedef struct packed {
        logic [31:0] blocks;
        logic [31:0] errors;
        logic [31:0] rate;
    } blerc_result_t;
endpackage : blerc_pkg

// ---- blerc_fifo.sv ----
module blerc_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clock, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic flush, // Drop all contents
    input wire logic in_valid, // Write request
    output logic in_ready, // Space available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Data available
    input wire logic out_ready, // Read accept
    output logic [WIDTH-1:0] out_data // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count < (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : blerc_fifo

// ---- blerc_crc16.sv ----
`include "blerc_cfg.svh"
module blerc_crc16 (
    input wire logic clock, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic clear, // Reload the seed
    input wire logic shift, // Absorb one bit
    input wire logic bit_in, // Bit to absorb
    output logic [15:0] crc // Running remainder
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? `BLERC_CRC_POLY : 16'h0000);
    endfunction : crc_step

    always_ff @(posedge clock) begin
        if (!rstn || clear) begin
            crc <= `BLERC_CRC_INIT;
        end else if (shift) begin
            crc <= crc_step(crc, bit_in);
        end
    end
endmodule : blerc_crc16

// ---- blerc_checker.sv ----
`include "blerc_cfg.svh"
module blerc_checker #(
    parameter int CLK_LOSS_CYC = `BLERC_CLK_LOSS_CYC
) (
    input wire logic clock, // System clock, 20 MHz
    input wire logic rstn, // Synchronous reset, active low
    input wire logic link_clk, // Bit clock pin from the device under test
    input wire logic link_data, // Serial data pin
    input wire logic link_enable, // Data enable pin
    input wire logic cfg_auto, // 1 continuous mode, 0 single mode
    input wire logic cfg_invert, // Data polarity inverted
    input wire logic cfg_enable_low, // User data while enable is low
    input wire logic cfg_crc_lsb_first, // Checksum low byte arrives first
    input wire logic [31:0] cfg_max_blocks, // Block limit
    input wire logic [31:0] cfg_max_errors, // Error limit
    input wire logic [31:0] cfg_timeout, // Time limit in clock cycles, 0 none
    input wire logic cmd_start, // Enable continuous measurement (one-cycle pulse)
    input wire logic cmd_stop, // User stop (one-cycle pulse)
    input wire logic cmd_single, // Single-shot trigger (one-cycle pulse)
    output logic running, // Measurement in progress
    output blerc_pkg::blerc_cause_t termination_cause, // Why the last run ended
    output blerc_pkg::blerc_result_t result, // Published counts and rate
    output logic result_final, // Result holds a completed run
    output logic stat_clock, // Bit clock detected
    output logic stat_data, // Data activity detected
    output logic stat_sync // Block framing synchronized
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } blerc_state_t;

    // Two-stage synchronisers; stage one feeds stage two only
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic clk_prev;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            clk_prev <= 1'b0;
        end else begin
            sync1 <= {link_clk, link_data, link_enable};
            sync2 <= sync1;
            clk_prev <= sync2[2];
        end
    end

    wire bit_tick = sync2[2] && !clk_prev;
    wire bit_value = sync2[1] ^ cfg_invert;
    wire bit_user = sync2[0] ^ cfg_enable_low;

    // Sampled bits are queued so the checker never loses one while it settles a block
    blerc_pkg::blerc_bit_t fifo_in;
    blerc_pkg::blerc_bit_t fifo_out;
    logic fifo_valid;
    logic fifo_in_ready;
    logic state_is_run;
    assign fifo_in.data = bit_value;
    assign fifo_in.user = bit_user;

    blerc_fifo #(
        .WIDTH(`BLERC_FIFO_W),
        .DEPTH(`BLERC_FIFO_D)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .flush(!state_is_run),
        .in_valid(bit_tick && state_is_run),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_out)
    );

    // Clock and data detection
    logic [31:0] clk_idle;
    logic [7:0] data_idle;
    logic data_prev;
    wire data_edge = bit_tick && (sync2[1] != data_prev);
    always_ff @(posedge clock) begin
        if (!rstn) begin
            clk_idle <= 32'h0;
            data_idle <= 8'h0;
            data_prev <= 1'b0;
            stat_clock <= 1'b0;
            stat_data <= 1'b0;
        end else begin
            clk_idle <= bit_tick ? 32'h0 : (stat_clock ? clk_idle + 32'h1 : clk_idle);
            if (bit_tick) begin
                stat_clock <= 1'b1;
                data_prev <= sync2[1];
                data_idle <= data_edge ? 8'h0 : data_idle + 8'h1;
                if (data_edge) begin
                    stat_data <= 1'b1;
                end else if (data_idle == 8'(`BLERC_DATA_IDLE_BITS)) begin
                    stat_data <= 1'b0;
                end
            end else if (clk_idle == CLK_LOSS_CYC) begin
                stat_clock <= 1'b0;
                stat_data <= 1'b0;
            end
        end
    end

    // Block framing: user bits feed the CRC, following 16 checksum bits are compared
    logic crc_clear;
    logic [15:0] crc_now;
    logic [15:0] crc_hold;
    logic [15:0] rx_crc;
    logic [4:0] rx_cnt;
    logic in_check;
    wire take = fifo_valid;
    wire user_bit = take && fifo_out.user;
    wire chk_bit = take && !fifo_out.user;

    blerc_crc16 u_crc (
        .clock(clock),
        .rstn(rstn),
        .clear(crc_clear),
        .shift(user_bit),
        .bit_in(fifo_out.data),
        .crc(crc_now)
    );

    // Checksum bytes arrive msb-first within each byte; byte order is a setting
    wire [15:0] rx_next = {rx_crc[14:0], fifo_out.data};
    wire [15:0] rx_ordered = cfg_crc_lsb_first ? {rx_next[7:0], rx_next[15:8]} : rx_next;
    wire block_done = chk_bit && (rx_cnt == 5'd15);
    wire block_bad = block_done && (rx_ordered != crc_hold);
    assign crc_clear = block_done || !state_is_run;

    always_ff @(posedge clock) begin
        if (!rstn || !state_is_run) begin
            rx_crc <= 16'h0;
            rx_cnt <= 5'h0;
            in_check <= 1'b0;
            crc_hold <= 16'h0;
        end else if (user_bit) begin
            in_check <= 1'b0;
            rx_cnt <= 5'h0;
        end else if (chk_bit) begin
            if (!in_check) begin
                crc_hold <= crc_now;
            end
            in_check <= !block_done;
            rx_crc <= rx_next;
            rx_cnt <= block_done ? 5'h0 : rx_cnt + 5'h1;
        end
    end

    // Measurement control
    blerc_state_t state;
    blerc_state_t next_state;
    logic [31:0] blocks;
    logic [31:0] errors;
    logic [31:0] elapsed;
    logic first_run;
    assign state_is_run = (state == ST_RUN);

    wire [31:0] next_blocks = blocks + 32'(block_done);
    wire [31:0] next_errors = errors + 32'(block_bad);
    wire hit_blocks = state_is_run && (next_blocks >= cfg_max_blocks) && (cfg_max_blocks != 0);
    wire hit_errors = state_is_run && (next_errors >= cfg_max_errors) && (cfg_max_errors != 0);
    wire hit_time = state_is_run && (cfg_timeout != 0) && (elapsed >= cfg_timeout);
    wire hit_user = state_is_run && cmd_stop;
    wire hit_any = hit_user || hit_blocks || hit_errors || hit_time;
    wire restart = hit_any && cfg_auto && !hit_user;

    // A user stop takes precedence, then block limit, error limit, time limit
    wire [3:0] next_cause = hit_user ? 4'h1 : hit_blocks ? 4'h2 : hit_errors ? 4'h4 : 4'h8;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE, ST_DONE: begin
                if ((cfg_auto && cmd_start) || (!cfg_auto && cmd_single)) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (hit_any && !restart) begin
                    next_state = ST_DONE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Rate as faulty blocks over checked blocks, scaled by 2^20
    function automatic logic [31:0] ratio(input logic [31:0] e, input logic [31:0] b);
        logic [63:0] num;
        num = {12'h0, e, 20'h0} >> 0;
        ratio = (b == 32'h0) ? 32'h0 : 32'(num / {32'h0, b});
    endfunction : ratio

    wire live = first_run || !cfg_auto;
    wire leave = state_is_run && hit_any;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= ST_IDLE;
            blocks <= 32'h0;
            errors <= 32'h0;
            elapsed <= 32'h0;
            first_run <= 1'b0;
            termination_cause <= blerc_pkg::BLERC_CAUSE_NONE;
            result <= '0;
            result_final <= 1'b0;
            running <= 1'b0;
            stat_sync <= 1'b0;
        end else begin
            state <= next_state;
            running <= (next_state == ST_RUN);
            stat_sync <= stat_clock && stat_data && state_is_run && block_done
                ? 1'b1 : (stat_clock && stat_data && stat_sync && state_is_run);
            if (leave || (!state_is_run && next_state == ST_RUN)) begin
                blocks <= 32'h0;
                errors <= 32'h0;
                elapsed <= 32'h0;
                first_run <= !state_is_run;
            end else if (state_is_run) begin
                blocks <= next_blocks;
                errors <= next_errors;
                elapsed <= elapsed + 32'h1;
            end
            if (leave) begin
                termination_cause <= blerc_pkg::blerc_cause_t'(next_cause);
                result.blocks <= next_blocks;
                result.errors <= next_errors;
                result.rate <= ratio(next_errors, next_blocks);
                result_final <= 1'b1;
            end else if (state_is_run && live) begin
                result.blocks <= next_blocks;
                result.errors <= next_errors;
                result.rate <= ratio(next_errors, next_blocks);
                result_final <= 1'b0;
            end else if (!state_is_run && next_state == ST_RUN && !cfg_auto) begin
                result <= '0;
                result_final <= 1'b0;
            end
        end
    end
endmodule : blerc_checker

// ---- blerc_monitor.sv ----
module blerc_monitor #(
    parameter int CLK_LOSS_CYC = 400
) (
    input wire logic clock, // System clock
    input wire logic rstn, // Reset, active low
    input wire logic cfg_auto, // Continuous mode
    input wire logic [31:0] cfg_max_blocks, // Block limit
    input wire logic [31:0] cfg_max_errors, // Error limit
    input wire logic cmd_start, // Start pulse
    input wire logic cmd_stop, // Stop pulse
    input wire logic cmd_single, // Single trigger
    input wire logic running, // Run active
    input blerc_pkg::blerc_cause_t termination_cause, // End cause
    input blerc_pkg::blerc_result_t result, // Counts and rate
    input wire logic result_final, // Finished run
    input wire logic stat_clock, // Clock seen
    input wire logic stat_data, // Data seen
    input wire logic stat_sync // Synchronized
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    user_stop_a: assert property (
        running && cmd_stop |=> !running && termination_cause == blerc_pkg::BLERC_CAUSE_USER)
        else $error("user stop did not end the run");
    block_limit_a: assert property (
        !cfg_auto && $fell(running) && termination_cause == blerc_pkg::BLERC_CAUSE_BLOCKS
        |-> result.blocks == cfg_max_blocks) else $error("block limit count wrong");
    error_limit_a: assert property (
        !cfg_auto && $fell(running) && termination_cause == blerc_pkg::BLERC_CAUSE_ERRORS
        |-> result.errors == cfg_max_errors) else $error("error limit count wrong");
    result_kept_a: assert property (
        !running && !cmd_start && !cmd_single |=> $stable(result) && $stable(termination_cause))
        else $error("result changed while idle");
    single_start_a: assert property (
        !cfg_auto && !running && cmd_single |=> running) else $error("single trigger ignored");
    single_once_a: assert property (
        !cfg_auto && $fell(running) && !cmd_single && !cmd_start |=> !running)
        else $error("single run restarted");
    rate_value_a: assert property (
        result_final && result.blocks != 0
        |-> 64'(result.rate) == (64'(result.errors) << 20) / 64'(result.blocks))
        else $error("error rate wrong");
    sync_needs_a: assert property (
        $rose(stat_sync) |-> stat_clock && stat_data) else $error("sync before clock and data");
endmodule : blerc_monitor

bind blerc_checker blerc_monitor #(.CLK_LOSS_CYC(CLK_LOSS_CYC)) i_monitor (
    .clock(clock), .rstn(rstn), .cfg_auto(cfg_auto), .cfg_max_blocks(cfg_max_blocks),
    .cfg_max_errors(cfg_max_errors), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_single(cmd_single), .running(running), .termination_cause(termination_cause),
    .result(result), .result_final(result_final), .stat_clock(stat_clock),
    .stat_data(stat_data), .stat_sync(stat_sync));

// ---- blerc_dut_model.sv ----
module blerc_dut_model (
    output logic link_clk, // Bit clock, still between frames
    output logic link_data, // Serial data
    output logic link_enable // Data enable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk = 1'b0;
        link_data = 1'b0;
        link_enable = 1'b0;
    end
    // Data settles half a bit before the rising clock edge, so setup and hold are equal
    task automatic put_bit(input logic b, input logic en);
        link_data = b;
        link_enable = en;
        #200 link_clk = 1'b1;
        #200 link_clk = 1'b0;
    endtask : put_bit
    // Bad flips the last checksum bit
    task automatic send_block(input logic [15:0] u, input logic bad, inv, en_low, lsb);
        logic [15:0] crc;
        logic [15:0] c;
        crc = 16'hffff;
        for (int i = 15; i >= 0; i--) begin
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ u[i]) ? 16'h1021 : 16'h0000);
            put_bit(u[i] ^ inv, !en_low);
        end
        c = (lsb ? {crc[7:0], crc[15:8]} : crc) ^ {15'h0000, bad};
        for (int i = 15; i >= 0; i--) begin
            put_bit(c[i] ^ inv, en_low);
        end
    endtask : send_block
endmodule : blerc_dut_model

// ---- testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cfg_auto = 1'b0;
    logic [2:0] cfg_mode = 3'h0; // Invert, enable low, low byte first
    logic [31:0] max_blk = 32'h0;
    logic [31:0] max_err = 32'h0;
    logic [31:0] tmo = 32'h0;
    logic [2:0] cmd = 3'h0; // Start, stop, single
    wire link_clk;
    wire link_data;
    wire link_enable;
    logic running;
    blerc_pkg::blerc_cause_t cause;
    blerc_pkg::blerc_result_t res;
    logic res_final;
    logic [2:0] stat;
    int n_mismatch = 0;
    int checks_done = 0;
`define CHK(nm, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("FAIL %s exp %0h got %0h", nm, e, g); \
    end \
end
    always #25 clock = ~clock;
    blerc_dut_model i_src (.link_clk(link_clk), .link_data(link_data), .link_enable(link_enable));
    blerc_checker i_dut (
        .clock(clock), .rstn(rstn), .link_clk(link_clk), .link_data(link_data),
        .link_enable(link_enable), .cfg_auto(cfg_auto), .cfg_invert(cfg_mode[2]),
        .cfg_enable_low(cfg_mode[1]), .cfg_crc_lsb_first(cfg_mode[0]),
        .cfg_max_blocks(max_blk), .cfg_max_errors(max_err), .cfg_timeout(tmo),
        .cmd_start(cmd[2]), .cmd_stop(cmd[1]), .cmd_single(cmd[0]), .running(running),
        .termination_cause(cause), .result(res), .result_final(res_final),
        .stat_clock(stat[2]), .stat_data(stat[1]), .stat_sync(stat[0]));
    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic pulse(input logic [2:0] c);
        cmd <= c;
        @(posedge clock);
        cmd <= 3'h0;
        repeat (2) @(posedge clock);
    endtask : pulse
    task automatic blk(input logic bad);
        // Keep pin changes off the sampling edge of the system clock
        #10;
        i_src.send_block(16'ha5c3, bad, cfg_mode[2], cfg_mode[1], cfg_mode[0]);
        repeat (8) @(posedge clock);
    endtask : blk
    task automatic wait_idle;
        int k;
        k = 0;
        while (running !== 1'b0 && k < 400) begin
            @(posedge clock);
            k++;
        end
        if (k == 400) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : wait_idle
    // Each setting takes both values across the four runs
    task automatic t_block_limit;
        logic [2:0] modes [4] = '{3'h0, 3'h3, 3'h5, 3'h6};
        `CHK("status idle", 3'h0, stat)
        foreach (modes[m]) begin
            cfg_mode <= modes[m];
            max_blk <= 32'h2;
            pulse(3'h1);
            blk(1'b0);
            `CHK("live blocks", 32'h1, res.blocks)
            blk(1'b1);
            wait_idle();
            `CHK("cause", blerc_pkg::BLERC_CAUSE_BLOCKS, cause)
            `CHK("errors", 32'h1, res.errors)
            `CHK("rate", 32'h80000, res.rate)
        end
    endtask : t_block_limit
    task automatic t_error_limit;
        max_blk <= 32'h0;
        max_err <= 32'h2;
        pulse(3'h1);
        blk(1'b1);
        blk(1'b0);
        `CHK("status", 3'h7, stat)
        blk(1'b1);
        wait_idle();
        `CHK("cause", blerc_pkg::BLERC_CAUSE_ERRORS, cause)
        `CHK("blocks", 32'h3, res.blocks)
        `CHK("rate", 32'haaaaa, res.rate)
    endtask : t_error_limit
    task automatic t_stop;
        max_err <= 32'h0;
        pulse(3'h1);
        blk(1'b0);
        pulse(3'h2);
        `CHK("cause", blerc_pkg::BLERC_CAUSE_USER, cause)
        `CHK("blocks", 32'h1, res.blocks)
    endtask : t_stop
    task automatic t_auto;
        cfg_auto <= 1'b1;
        max_blk <= 32'h2;
        pulse(3'h4);
        blk(1'b0);
        `CHK("first run live", 32'h1, res.blocks)
        blk(1'b0);
        `CHK("restarted", 1'b1, running)
        `CHK("cause", blerc_pkg::BLERC_CAUSE_BLOCKS, cause)
        blk(1'b0);
        `CHK("finals only", 33'h100000002, {res_final, res.blocks})
        pulse(3'h2);
        `CHK("stopped", 1'b0, running)
        cfg_auto <= 1'b0;
    endtask : t_auto
    task automatic t_timeout;
        max_blk <= 32'h0;
        tmo <= 32'h64;
        pulse(3'h1);
        wait_idle();
        `CHK("cause", blerc_pkg::BLERC_CAUSE_TIMEOUT, cause)
        repeat (400) @(posedge clock);
        `CHK("clock lost", 3'h0, stat)
    endtask : t_timeout
    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_block_limit();
        t_error_limit();
        t_stop();
        t_auto();
        t_timeout();
        end_of_test();
    end
endmodule : testbench
